// file: inc/pmx_defs.vh
// Register map, field layout and codes for the pad mux block
`ifndef PMX_DEFS_VH
`define PMX_DEFS_VH

// Register indices; byte address is four times the index
`define PMX_IDX_CLK_MUX_CFG   12'h0453
`define PMX_IDX_FORCE_A       12'h0454
`define PMX_IDX_TEST_CTRL     12'h0455
`define PMX_IDX_RGMII_SLEW    12'h0456
`define PMX_IDX_LEVEL_STAT_A  12'h0457

// Reset values
`define PMX_RST_CLK_MUX_CFG   16'h0001
`define PMX_RST_FORCE_A       16'h0000
`define PMX_RST_TEST_CTRL     16'h0000
`define PMX_RST_RGMII_SLEW    16'h0108

// Writable bit masks, all else reads zero
`define PMX_WMASK_CLK_MUX_CFG 16'h003F
`define PMX_WMASK_FORCE_A     16'hFFFF
`define PMX_WMASK_TEST_CTRL   16'h3FFF
`define PMX_WMASK_RGMII_SLEW  16'h03FF

// Clock mux config fields
`define PMX_FUNC_LSB          0
`define PMX_SRC_LSB           3

// Test control fields
`define PMX_FORCE_B_LSB       0
`define PMX_OVR_BIT           4
`define PMX_DIR_BIT           5
`define PMX_PULL_OVR_BIT      6
`define PMX_PULL_LSB          7
`define PMX_CLK_SLEW_LSB      9

// RGMII slew field
`define PMX_RGMII_SLEW_LSB    5

// Clock source codes
`define PMX_SRC_XTAL          3'h0
`define PMX_SRC_FAST_A        3'h3
`define PMX_SRC_FAST_B        3'h4

// Clock pad function codes
`define PMX_FN_ACT_LED        3'h0
`define PMX_FN_CLOCK          3'h1
`define PMX_FN_DATA_MATCH     3'h2
`define PMX_FN_UNDERVOLT      3'h3
`define PMX_FN_HIGH           3'h7

// Pad positions
`define PMX_PAD_CLOCK         2
`define PMX_NUM_PADS          20
`define PMX_STAT_PADS         16

`endif

// file: sim/pad_mux_and_io_test_override_bench.sv
// Self-checking bench for the pad mux and test override block
`default_nettype none
`include "pmx_defs.vh"
module pad_mux_and_io_test_override_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] MX = `PMX_IDX_CLK_MUX_CFG;
    localparam logic [11:0] FA = `PMX_IDX_FORCE_A;
    localparam logic [11:0] TC = `PMX_IDX_TEST_CTRL;
    localparam logic [11:0] RS = `PMX_IDX_RGMII_SLEW;
    localparam logic [11:0] ST = `PMX_IDX_LEVEL_STAT_A;
    logic        clk, rst, cyc, stb, we, ack, xtal, fast, act, dm, uv;
    logic [13:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat, dout;
    logic [19:0] f_out, f_oe, f_pu, f_pd, p_in, p_out, p_oe, p_pu, p_pd;
    logic [19:0] ext_en, ext_val;
    logic [4:0]  s_clk, s_rg;
    int          n_fail, check_count;
    pmx_pad_ctrl dut (
        .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dout), .ack_o(ack),
        .xtal_clk_i(xtal), .fast_clk_i(fast), .act_led_i(act),
        .data_match_i(dm), .undervolt_i(uv), .func_out_i(f_out),
        .func_oe_i(f_oe), .func_pu_i(f_pu), .func_pd_i(f_pd),
        .pad_in_i(p_in), .pad_out_o(p_out), .pad_oe_o(p_oe),
        .pad_pu_o(p_pu), .pad_pd_o(p_pd), .clk_pad_slew_o(s_clk),
        .rgmii_pad_slew_o(s_rg));
    pmx_pad_board brd (
        .clk_i(clk), .out_i(p_out), .oe_i(p_oe), .pu_i(p_pu), .pd_i(p_pd),
        .ext_en_i(ext_en), .ext_val_i(ext_val), .lvl_o(p_in));
    task automatic stop_test;
        $display("%0d checks, %0d mismatches", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One classic cycle; waits for ack under a bound
    task automatic wb(input logic w, input logic [11:0] ix,
                      input logic [15:0] d, output logic [15:0] q);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {ix, 2'b00};
        dat <= {16'h0000, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = dout[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            n_fail++;
            stop_test;
        end
    endtask
    task automatic wr(input logic [11:0] ix, input logic [15:0] d);
        logic [15:0] q;
        wb(1'b1, ix, d, q);
    endtask
    task automatic rc(input logic [11:0] ix, input logic [15:0] e);
        logic [15:0] q;
        wb(1'b0, ix, 16'h0000, q);
        chk({16'h0000, q}, {16'h0000, e});
    endtask
    task automatic t_reset;
        rc(MX, 16'h0001);
        rc(FA, 16'h0000);
        rc(TC, 16'h0000);
        rc(RS, 16'h0108);
        rc(ST, 16'h0000);
        rc(12'h0400, 16'h0000);
        $display("reset values done");
    endtask
    // Indications at 1,0,1; clocks swapped on the second pass
    task automatic t_mux;
        logic e;
        for (int k = 0; k < 2; k++) begin
            xtal <= k[0];
            fast <= !k[0];
            for (int s = 0; s < 8; s++) begin
                wr(MX, 16'(s * 8 + 1));
                e = (s == 0) ? k[0] : (s == 3 || s == 4) ? !k[0] : 1'b0;
                chk(p_out[2], e);
            end
        end
        // Source 0 with the crystal line high, so function 1 reads 1
        for (int f = 0; f < 8; f++) begin
            wr(MX, 16'(f));
            chk(p_out[2], 8'h8B >> f & 1);
        end
        wr(MX, 16'hFFFF);
        rc(MX, 16'h003F);
        wr(MX, 16'h0001);
        $display("clock pad mux done");
    endtask
    task automatic t_force;
        wr(FA, 16'hA5C3);
        wr(TC, 16'h0015);
        chk(p_out, 20'h5_A5C3);
        chk(p_oe, 20'hF_FFFF);
        wr(FA, 16'h5A3C);
        wr(TC, 16'h001A);
        chk(p_out, 20'hA_5A3C);
        $display("forced output done");
    endtask
    task automatic t_dir;
        ext_en <= 20'hF_FFFF;
        ext_val <= 20'h0_6C9A;
        wr(TC, 16'h0030);
        chk(p_oe, 20'h0_0000);
        repeat (4) @(posedge clk);
        wr(ST, 16'hFFFF);
        rc(ST, 16'h6C9A);
        ext_val <= 20'hF_9365;
        repeat (4) @(posedge clk);
        rc(ST, 16'h9365);
        wr(TC, 16'h0000);
        ext_en <= 20'h0_0000;
        chk(p_oe, f_oe);
        rc(ST, 16'h0000);
        $display("input direction done");
    endtask
    task automatic t_pull;
        for (int p = 0; p < 4; p++) begin
            wr(TC, 16'(16'h0040 + p * 128));
            chk(p_pu, {20{p[0]}});
            chk(p_pd, {20{p[1]}});
        end
        wr(TC, 16'h0000);
        chk(p_pu, f_pu);
        chk(p_pd, f_pd);
        $display("pull override done");
    endtask
    task automatic t_slew;
        logic [4:0] rg[3] = '{5'h0A, 5'h0B, 5'h08};
        for (int c = 0; c < 3; c++) begin
            wr(TC, 16'(c * 512));
            chk(s_clk, 5'(c));
            wr(RS, 16'({rg[c], 5'h08}));
            chk(s_rg, rg[c]);
        end
        wr(TC, 16'hFFFF);
        rc(TC, 16'h3FFF);
        wr(RS, 16'hFFFF);
        rc(RS, 16'h03FF);
        wr(TC, 16'h0000);
        $display("slew fields done");
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        {cyc, stb, we, adr, dat, dm} = '0;
        sel = 4'h3;
        {xtal, fast, act, uv} = 4'h7;
        f_out = 20'h5_A5A5;
        f_oe = 20'h0_F0F0;
        f_pu = 20'hC_3C3C;
        f_pd = 20'h3_0303;
        {ext_en, ext_val} = '0;
        n_fail = 0;
        check_count = 0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_mux;
        t_force;
        t_dir;
        t_pull;
        t_slew;
        stop_test;
    end
endmodule
`default_nettype wire

// file: sim/pmx_pad_board.sv
// Board model: pins, pull resistors and external pin drivers
`default_nettype none
module pmx_pad_board #(
    parameter int N = 20
) (
    input  wire logic         clk_i,
    input  wire logic [N-1:0] out_i,
    input  wire logic [N-1:0] oe_i,
    input  wire logic [N-1:0] pu_i,
    input  wire logic [N-1:0] pd_i,
    input  wire logic [N-1:0] ext_en_i,
    input  wire logic [N-1:0] ext_val_i,
    output var logic  [N-1:0] lvl_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [N-1:0] prev_q;
    // Floating pins wander, so a stale level never passes for a read
    always @(posedge clk_i) begin
        prev_q <= lvl_o;
    end
    // Pad drive wins, then the external driver, then a single pull
    always_comb begin
        for (int i = 0; i < N; i++) begin
            if (oe_i[i]) begin
                lvl_o[i] = out_i[i];
            end else if (ext_en_i[i]) begin
                lvl_o[i] = ext_val_i[i];
            end else if (pu_i[i] != pd_i[i]) begin
                lvl_o[i] = pu_i[i];
            end else begin
                lvl_o[i] = ~prev_q[i];
            end
        end
    end
endmodule
`default_nettype wire

// file: sim/pmx_pad_ctrl_asserts.sv
// Assertion checker for the pad mux and test override block
`default_nettype none
`include "pmx_defs.vh"
module pmx_pad_ctrl_asserts #(
    parameter NPADS = 20,
    parameter AW    = 14
) (
    input wire logic             clk_i,
    input wire logic             rst_i,
    input wire logic             cyc_i,
    input wire logic             stb_i,
    input wire logic             we_i,
    input wire logic [AW-1:0]    adr_i,
    input wire logic [3:0]       sel_i,
    input wire logic [31:0]      dat_i,
    input wire logic [31:0]      dat_o,
    input wire logic             ack_o,
    input wire logic             xtal_clk_i,
    input wire logic [NPADS-1:0] func_oe_i,
    input wire logic [NPADS-1:0] func_pu_i,
    input wire logic [NPADS-1:0] func_pd_i,
    input wire logic [NPADS-1:0] pad_out_o,
    input wire logic [NPADS-1:0] pad_oe_o,
    input wire logic [NPADS-1:0] pad_pu_o,
    input wire logic [NPADS-1:0] pad_pd_o,
    input wire logic [4:0]       clk_pad_slew_o,
    input wire logic [4:0]       rgmii_pad_slew_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mx_q, fa_q, tc_q, rs_q;
    wire logic [15:0] bm = {{8{sel_i[1]}}, {8{sel_i[0]}}};
    wire logic [15:0] nd = dat_i[15:0] & bm;
    wire logic        tk = cyc_i & stb_i & ~ack_o;
    wire logic [11:0] ix = adr_i[13:2];
    // Shadow registers; byte lanes honoured so partial writes stay true
    always @(posedge clk_i) begin
        if (rst_i) begin
            mx_q <= 16'h0001;
            fa_q <= 16'h0000;
            tc_q <= 16'h0000;
            rs_q <= 16'h0108;
        end else if (tk && we_i) begin
            case (ix)
                `PMX_IDX_CLK_MUX_CFG: mx_q <= (mx_q & ~bm) | nd;
                `PMX_IDX_FORCE_A:     fa_q <= (fa_q & ~bm) | nd;
                `PMX_IDX_TEST_CTRL:   tc_q <= (tc_q & ~bm) | nd;
                `PMX_IDX_RGMII_SLEW:  rs_q <= (rs_q & ~bm) | nd;
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_next: assert property (
        tk |=> ack_o) else $error("no answer");
    a_ack_pulse: assert property (
        $rose(ack_o) |=> !ack_o) else $error("ack too long");
    a_force_value: assert property (
        tc_q[4] && !tc_q[5] |-> pad_out_o == {tc_q[3:0], fa_q})
        else $error("forced value wrong");
    a_test_dir: assert property (
        tc_q[4] |-> pad_oe_o == {NPADS{!tc_q[5]}}) else $error("test dir");
    a_func_dir: assert property (
        !tc_q[4] |-> pad_oe_o == func_oe_i) else $error("func dir");
    a_pull_force: assert property (
        tc_q[6] |-> pad_pu_o == {NPADS{tc_q[7]}}
        && pad_pd_o == {NPADS{tc_q[8]}}) else $error("test pull");
    a_pull_func: assert property (
        !tc_q[6] |-> pad_pu_o == func_pu_i && pad_pd_o == func_pd_i)
        else $error("func pull");
    a_slew_pass: assert property (
        clk_pad_slew_o == tc_q[13:9] && rgmii_pad_slew_o == rs_q[9:5])
        else $error("slew");
    a_clk_high: assert property (
        !tc_q[4] && mx_q[2:0] == 3'h7 |-> pad_out_o[2])
        else $error("const high");
    a_clk_xtal: assert property (
        !tc_q[4] && mx_q[5:0] == 6'h01 |-> pad_out_o[2] == xtal_clk_i)
        else $error("xtal route");
    a_stat_zero: assert property (
        tk && !we_i && ix == `PMX_IDX_LEVEL_STAT_A && !(tc_q[4] && tc_q[5])
        |=> dat_o == 32'h0000_0000) else $error("status not zero");
    c_dir_in: cover property (tc_q[4] && tc_q[5]);
    c_pull: cover property (tc_q[6] && tc_q[8:7] == 2'h3);
    c_clock: cover property (!tc_q[4] && mx_q[2:0] == 3'h1);
endmodule
bind pmx_pad_ctrl pmx_pad_ctrl_asserts #(.NPADS(NPADS), .AW(AW)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .xtal_clk_i(xtal_clk_i),
    .func_oe_i(func_oe_i), .func_pu_i(func_pu_i), .func_pd_i(func_pd_i),
    .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .pad_pu_o(pad_pu_o),
    .pad_pd_o(pad_pd_o), .clk_pad_slew_o(clk_pad_slew_o),
    .rgmii_pad_slew_o(rgmii_pad_slew_o));
`default_nettype wire

// file: src/pmx_clk_mux.v
// Source and function selection for the clock output pad
`include "pmx_defs.vh"
`default_nettype none

module pmx_clk_mux (
    input  wire [2:0] src_sel_i,
    input  wire [2:0] func_sel_i,
    input  wire       xtal_clk_i,
    input  wire       fast_clk_i,
    input  wire       act_led_i,
    input  wire       data_match_i,
    input  wire       undervolt_i,
    output reg        pad_value_o
);

    reg sel_clk;

    // Clock source; reserved codes park the line low
    always @* begin
        case (src_sel_i)
            `PMX_SRC_XTAL:   sel_clk = xtal_clk_i;
            `PMX_SRC_FAST_A: sel_clk = fast_clk_i;
            `PMX_SRC_FAST_B: sel_clk = fast_clk_i;
            default:         sel_clk = 1'b0;
        endcase
    end

    // Pad function; the three unused codes give constant low
    always @* begin
        case (func_sel_i)
            `PMX_FN_ACT_LED:    pad_value_o = act_led_i;
            `PMX_FN_CLOCK:      pad_value_o = sel_clk;
            `PMX_FN_DATA_MATCH: pad_value_o = data_match_i;
            `PMX_FN_UNDERVOLT:  pad_value_o = undervolt_i;
            `PMX_FN_HIGH:       pad_value_o = 1'b1;
            default:            pad_value_o = 1'b0;
        endcase
    end

endmodule

`default_nettype wire

// file: src/pmx_pad_ctrl.v
// Pad mux, IO test override and its Wishbone register file
//
// Register words, 16 bits in the low half of each bus word:
//   0x453  clock_pad_mux_config: pad function and clock source
//   0x454  pad_force_value_a: forced values, positions 0 to 15
//   0x455  pad_test_control: forced values 16 to 19, override,
//          direction, pull override, pull code, clock pad slew
//   0x456  rgmii_pad_slew_control: bits 4:0 held, no effect
//   0x457  pad_level_status_a: sampled levels, read only
//
// Pad positions, shared by forced values and status:
//   0      LED0 output
//   1      LED1 output
//   2      clock output pad, fed by the clock mux
//   3      interrupt output
//   4, 5   no pad; outputs exist but go nowhere
//   6      inhibit pad
//   7      RGMII transmit clock
//   8      RGMII transmit control
//   9-12   RGMII transmit data 0 to 3
//   13     RGMII receive clock
//   14     RGMII receive control
//   15     RGMII receive data 0
//   16-18  RGMII receive data 1 to 3
//   19     strap pad
//
// Limitations: status covers positions 0 to 15 only; override
// and pull override act on all 20 positions at once, with no
// per-pad selection.
//
// Clock paths reach the clock pad through gates only; sampling
// them on the block clock would destroy the clock.
//
// Functional notes
// - Clock source 000 gives crystal clock, 011 and 100 fast clock.
// - Clock pad function: LED, clock, match, undervoltage, low, high.
// - Override with direction 0 drives each pad at its forced value.
// - First forced-value register covers pads 0 to 15 in order.
// - Second forced-value field covers receive data 1 to 3, strap.
// - Override bit takes direction and value away from functional logic.
// - Direction bit acts only under override: 0 output, 1 input.
// - Pull override applies the test pull setting to every pad.
// - Test pull: none, up, down, or both up and down.
// - Clock pad slew field is passed to the pad cell.
// - RGMII slew field is passed to the RGMII pad cells.
// - Override with direction 1 lets status read sampled pad levels.
//
// Local design decision: register access over Wishbone.
`include "pmx_defs.vh"
`default_nettype none

module pmx_pad_ctrl #(
    parameter NPADS = `PMX_NUM_PADS,
    parameter AW    = 14
) (
    input  wire             clk_i,
    input  wire             rst_i,
    // Wishbone classic slave
    input  wire             cyc_i,
    input  wire             stb_i,
    input  wire             we_i,
    input  wire [AW-1:0]    adr_i,
    input  wire [3:0]       sel_i,
    input  wire [31:0]      dat_i,
    output reg  [31:0]      dat_o,
    output reg              ack_o,
    // Sources for the clock output pad
    input  wire             xtal_clk_i,
    input  wire             fast_clk_i,
    input  wire             act_led_i,
    input  wire             data_match_i,
    input  wire             undervolt_i,
    // Functional pad control
    input  wire [NPADS-1:0] func_out_i,
    input  wire [NPADS-1:0] func_oe_i,
    input  wire [NPADS-1:0] func_pu_i,
    input  wire [NPADS-1:0] func_pd_i,
    // Pad cells
    input  wire [NPADS-1:0] pad_in_i,
    output wire [NPADS-1:0] pad_out_o,
    output wire [NPADS-1:0] pad_oe_o,
    output wire [NPADS-1:0] pad_pu_o,
    output wire [NPADS-1:0] pad_pd_o,
    output wire [4:0]       clk_pad_slew_o,
    output wire [4:0]       rgmii_pad_slew_o
);

    localparam SP = `PMX_STAT_PADS;

    // Stored registers
    // Each has a next value and a flop of its own
    reg  [15:0] clk_mux_cfg_q;
    reg  [15:0] clk_mux_cfg_d;
    reg  [15:0] force_a_q;
    reg  [15:0] force_a_d;
    reg  [15:0] test_ctrl_q;
    reg  [15:0] test_ctrl_d;
    reg  [15:0] rgmii_slew_q;
    reg  [15:0] rgmii_slew_d;
    reg  [15:0] level_stat_q;
    reg  [15:0] level_stat_d;

    // Bus decode
    wire [11:0] reg_idx;
    wire        req;
    wire        wr_stb;
    wire        wr_mux;
    wire        wr_fa;
    wire        wr_tc;
    wire        wr_rs;
    wire [15:0] wmask_sel;
    wire        hit_mux;
    wire        hit_fa;
    wire        hit_tc;
    wire        hit_rs;
    wire        hit_st;
    reg  [15:0] rd_val;

    // Pad control fields
    wire        ovr;
    wire        dir_in;
    wire        pull_ovr;
    wire [1:0]  pull_sel;
    wire [NPADS-1:0] frc_val;
    wire [NPADS-1:0] fn_out;
    wire        clk_pad_val;
    wire [SP-1:0]    pad_sync;

    // Index taken from the word address; low two bits ignored
    assign reg_idx = adr_i[13:2];
    assign req     = cyc_i & stb_i & ~ack_o;
    assign wr_stb  = req & we_i;
    assign hit_mux = (reg_idx == `PMX_IDX_CLK_MUX_CFG);
    assign hit_fa  = (reg_idx == `PMX_IDX_FORCE_A);
    assign hit_tc  = (reg_idx == `PMX_IDX_TEST_CTRL);
    assign hit_rs  = (reg_idx == `PMX_IDX_RGMII_SLEW);
    assign hit_st  = (reg_idx == `PMX_IDX_LEVEL_STAT_A);

    // Byte lanes 0 and 1 carry the 16-bit register
    assign wmask_sel = {{8{sel_i[1]}}, {8{sel_i[0]}}};

    // Field extraction
    assign ovr      = test_ctrl_q[`PMX_OVR_BIT];
    assign dir_in   = test_ctrl_q[`PMX_DIR_BIT];
    assign pull_ovr = test_ctrl_q[`PMX_PULL_OVR_BIT];
    assign pull_sel = test_ctrl_q[`PMX_PULL_LSB +: 2];

    // Slew fields go straight to the pad cells
    // Unlisted codes pass unchanged; the pad cell decides
    assign clk_pad_slew_o   = test_ctrl_q[`PMX_CLK_SLEW_LSB +: 5];
    assign rgmii_pad_slew_o =
        rgmii_slew_q[`PMX_RGMII_SLEW_LSB +: 5];

    // Forced values: pads 0..15 then receive data 1..3 and strap
    // Lower sixteen follow the same order as the status bits
    assign frc_val = {test_ctrl_q[`PMX_FORCE_B_LSB +: 4],
                      force_a_q};

    // One write strobe per writable register; status has none
    assign wr_mux = wr_stb & hit_mux;
    assign wr_fa  = wr_stb & hit_fa;
    assign wr_tc  = wr_stb & hit_tc;
    assign wr_rs  = wr_stb & hit_rs;

    // Clock mux config next value; mask keeps bits 15:6 at zero
    always @* begin
        clk_mux_cfg_d = clk_mux_cfg_q;
        if (wr_mux) begin
            clk_mux_cfg_d = ((clk_mux_cfg_q & ~wmask_sel) |
                             (dat_i[15:0] & wmask_sel)) &
                            `PMX_WMASK_CLK_MUX_CFG;
        end
    end

    // Clock mux config storage; reset routes the crystal clock
    always @(posedge clk_i) begin
        if (rst_i) begin
            clk_mux_cfg_q <= `PMX_RST_CLK_MUX_CFG;
        end else begin
            clk_mux_cfg_q <= clk_mux_cfg_d;
        end
    end

    // Forced values next value; every bit writable
    always @* begin
        force_a_d = force_a_q;
        if (wr_fa) begin
            force_a_d = ((force_a_q & ~wmask_sel) |
                         (dat_i[15:0] & wmask_sel)) &
                        `PMX_WMASK_FORCE_A;
        end
    end

    // Forced values storage; reset forces nothing until override
    always @(posedge clk_i) begin
        if (rst_i) begin
            force_a_q <= `PMX_RST_FORCE_A;
        end else begin
            force_a_q <= force_a_d;
        end
    end

    // Test control next value; bits 15:14 read zero
    always @* begin
        test_ctrl_d = test_ctrl_q;
        if (wr_tc) begin
            test_ctrl_d = ((test_ctrl_q & ~wmask_sel) |
                           (dat_i[15:0] & wmask_sel)) &
                          `PMX_WMASK_TEST_CTRL;
        end
    end

    // Test control storage; reset leaves override and pulls off
    always @(posedge clk_i) begin
        if (rst_i) begin
            test_ctrl_q <= `PMX_RST_TEST_CTRL;
        end else begin
            test_ctrl_q <= test_ctrl_d;
        end
    end

    // RGMII slew next value; bits 15:10 read zero
    always @* begin
        rgmii_slew_d = rgmii_slew_q;
        if (wr_rs) begin
            rgmii_slew_d = ((rgmii_slew_q & ~wmask_sel) |
                            (dat_i[15:0] & wmask_sel)) &
                           `PMX_WMASK_RGMII_SLEW;
        end
    end

    // RGMII slew storage; reset picks the default pad slew
    always @(posedge clk_i) begin
        if (rst_i) begin
            rgmii_slew_q <= `PMX_RST_RGMII_SLEW;
        end else begin
            rgmii_slew_q <= rgmii_slew_d;
        end
    end

    // Pad levels pass two flops before anything reads them
    // Upper four levels are never read, so they are not synchronised
    pmx_sync #(
        .WIDTH (SP)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (pad_in_i[SP-1:0]),
        .sync_o  (pad_sync)
    );

    // Status shows sampled levels only in override input mode
    // Otherwise zero, so a pad the block drives is never mistaken
    // for an external level
    always @* begin
        if (ovr && dir_in) begin
            level_stat_d = pad_sync;
        end else begin
            level_stat_d = 16'h0000;
        end
    end

    // Status flop; adds one cycle after the synchroniser
    // Pad change to status: three edges in all
    always @(posedge clk_i) begin
        if (rst_i) begin
            level_stat_q <= 16'h0000;
        end else begin
            level_stat_q <= level_stat_d;
        end
    end

    // Clock pad source and function
    pmx_clk_mux u_clk_mux (
        .src_sel_i    (clk_mux_cfg_q[`PMX_SRC_LSB +: 3]),
        .func_sel_i   (clk_mux_cfg_q[`PMX_FUNC_LSB +: 3]),
        .xtal_clk_i   (xtal_clk_i),
        .fast_clk_i   (fast_clk_i),
        .act_led_i    (act_led_i),
        .data_match_i (data_match_i),
        .undervolt_i  (undervolt_i),
        .pad_value_o  (clk_pad_val)
    );

    // Per-pad override; kept combinational so a routed clock is
    // not resampled on the way to the pad
    genvar gi;
    generate
        for (gi = 0; gi < NPADS; gi = gi + 1) begin : g_pad
            // Clock pad takes the mux output, others their own value
            if (gi == `PMX_PAD_CLOCK) begin : g_clk
                assign fn_out[gi] = clk_pad_val;
            end else begin : g_plain
                assign fn_out[gi] = func_out_i[gi];
            end
            // Test value replaces the functional value
            assign pad_out_o[gi] = ovr ? frc_val[gi]
                                       : fn_out[gi];
            // Direction 0 drives, 1 releases the pad
            assign pad_oe_o[gi]  = ovr ? ~dir_in
                                       : func_oe_i[gi];
            // Pull code bit 0 is up, bit 1 is down
            assign pad_pu_o[gi]  = pull_ovr ? pull_sel[0]
                                            : func_pu_i[gi];
            assign pad_pd_o[gi]  = pull_ovr ? pull_sel[1]
                                            : func_pd_i[gi];
        end
    endgenerate

    // Read mux; unmapped addresses read zero
    // Status word is already zero outside override input mode
    always @* begin
        rd_val = 16'h0000;
        if (hit_mux) begin
            rd_val = clk_mux_cfg_q;
        end
        if (hit_fa) begin
            rd_val = force_a_q;
        end
        if (hit_tc) begin
            rd_val = test_ctrl_q;
        end
        if (hit_rs) begin
            rd_val = rgmii_slew_q;
        end
        if (hit_st) begin
            rd_val = level_stat_q;
        end
    end

    // Single wait state: a request taken at one edge is acked at
    // that edge, and the master sees ack at the next; ack drops in
    // the following cycle and req is blocked while ack is high, so
    // a held strobe is never taken twice. Writes land at the ack
    // edge. Unmapped accesses are acked too, reading zero, so a
    // stray access never hangs the bus.
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= req;
            if (req && !we_i) begin
                dat_o <= {16'h0000, rd_val};
            end
        end
    end

endmodule

`default_nettype wire

// file: src/pmx_sync.v
// Two flip-flop synchroniser bank for asynchronous pad levels
`default_nettype none

module pmx_sync #(
    parameter WIDTH = 16
) (
    input  wire             clk_i,
    input  wire             rst_i,
    input  wire [WIDTH-1:0] async_i,
    output reg  [WIDTH-1:0] sync_o
);

    // First stage feeds only the second stage
    reg [WIDTH-1:0] meta_q;

    // Plain double flop, cleared on reset
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= {WIDTH{1'b0}};
            sync_o <= {WIDTH{1'b0}};
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule

`default_nettype wire

// file: src/pmx_top_unused_guard.v
// Holds no logic; the pad block lives in pmx_pad_ctrl.v
